// ### svfc_consts.vh
/*
 Constants for the synchronous voltage-to-frequency converter model:
 register offsets, field positions, reset values and timing counts.
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef SVFC_CONSTS_VH
`define SVFC_CONSTS_VH

// Register byte offsets on the APB
`define SVFC_OFS_CTRL 12'h000
`define SVFC_OFS_IN_ONE 12'h004
`define SVFC_OFS_IN_TWO 12'h008
`define SVFC_OFS_IN_THREE 12'h00C
`define SVFC_OFS_IN_COMMON 12'h010
`define SVFC_OFS_STATUS 12'h014
`define SVFC_OFS_RATE 12'h018

// Control field positions
`define SVFC_CTRL_CHAN_LSB 0
`define SVFC_CTRL_CHAN_MSB 1
`define SVFC_CTRL_GAIN 2
`define SVFC_CTRL_POL 3
`define SVFC_CTRL_SINGLE 4
`define SVFC_CTRL_XTAL 5
`define SVFC_CTRL_SLEEP_N 6

// Control reset value: channel 00, gain 1, bipolar, multichannel, external clock, awake
`define SVFC_CTRL_RESET 7'h40

// Status field positions
`define SVFC_ST_VALID 0
`define SVFC_ST_SETTLING 1
`define SVFC_ST_OSC_READY 2
`define SVFC_ST_ASLEEP 3

// Rate fractions of the master clock, in percent
`define SVFC_RATE_MIN_PCT 5
`define SVFC_RATE_MAX_PCT 45

// Settling in master clock cycles for each variant
`define SVFC_SETTLE_MULTI 2
`define SVFC_SETTLE_SINGLE 10

// Oscillator start-up time and the clock rate it is counted at
`define SVFC_OSC_START_US 5000
`define SVFC_CLK_MHZ 10

`endif

// ### svfc_pulse_assertions.sv
/*
 Port checks for the pulse converter model.
 Assumes a bind from the bench; one clock, async active-low reset.
*/
module svfc_pulse_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire sleep_n,
    input wire pulse_out,
    input wire clock_echo_out,
    input wire out_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Everything lives in the pclk domain
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pulse_width: assert property (pulse_out |=> !pulse_out)
        else $error("pulse wider than one clock");
    a_rate_floor: assert property (out_valid && pulse_out |=> ##[0:21] (pulse_out || !out_valid))
        else $error("pulse gap beyond the lowest rate");
    a_sleep_quiet: assert property (!sleep_n [*2] |-> !pulse_out)
        else $error("pulse while asleep");
    a_sleep_invalid: assert property (!sleep_n [*2] |-> !out_valid)
        else $error("valid while asleep");
    a_echo_toggle: assert property (1'b1 |=> clock_echo_out != $past(clock_echo_out))
        else $error("clock echo stalled");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held over one cycle");
    a_ready_delay: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("answer not in second cycle");
    a_error_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule

// ### svfc_pulse_counter.sv
/*
 Gated pulse counter at the converter's pulse output.
 Assumes pulses synchronous to pclk; gate and clear come from the bench.
*/
module svfc_pulse_counter (
    input wire pclk,
    input wire presetn,
    input wire clear,
    input wire gate,
    input wire pulse_in,
    output logic [15:0] count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last;
    // Rising edges only, so a stuck-high output counts once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 1'b0;
            count <= 16'h0000;
        end else begin
            last <= pulse_in;
            if (clear)
                count <= 16'h0000;
            else if (gate && pulse_in && !last)
                count <= count + 16'h0001;
        end
    end
endmodule

// ### svfc_pulse_top.v
/*
 Synchronous voltage-to-frequency converter model with an APB register
 port. Input words stand in for the analog pins; the pulse output is
 meant for a gated counter or an opto-isolator. Assumes pclk is the
 master clock and all inputs are synchronous to it.
 Assumes software, not pins, selects channel, span, variant and clock source,
 and that any external counter gates on a divided copy of pclk.
*/
// The register offsets and the APB interface to the registers were left to the implementer.
//
// Function
// - channel code picks input pair
// - gain and polarity set the span
// - rate 0.05 to 0.45 of clock
// - pulse width is one clock high phase (model: one full pclk period)
// - pulses start on master clock edges
// - output invalid during settling cycles
// - sleep low stops pulse generation
// - crystal mode waits for oscillator start
// - master clock echoed on echo pin
// - rate depends only on difference
// - single-channel: unipolar, gain one, input one
// - external clock echo is inverted clock (model: registered toggle at half rate)
`include "svfc_consts.vh"

module svfc_pulse_top #(
    parameter DW = 16,
    parameter OSC_START_CYC = `SVFC_OSC_START_US * `SVFC_CLK_MHZ
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sleep_n,
    output reg pulse_out,
    output reg clock_echo_out,
    output reg out_valid
);
    localparam ACC_W = DW + 8;
    // Floor step: one twentieth of the modulus, so a zero code gives 0.05
    localparam [ACC_W-1:0] FLOOR_INC = {{(ACC_W-DW){1'b0}}, {DW{1'b1}}};
    // Modulus of twenty floor steps, built from shifts to keep its width exact
    localparam [ACC_W-1:0] MODULUS = (FLOOR_INC << 4) + (FLOOR_INC << 2);

    // APB state
    localparam ST_IDLE = 2'd0;
    localparam ST_RD = 2'd1;
    localparam ST_ACK = 2'd2;

    // Bus-written state, live inputs and generator state
    reg [1:0] st;
    reg [6:0] ctrl;
    reg [DW-1:0] in_one, in_two, in_three, in_common;
    reg [31:0] osc_cnt;
    reg osc_ready;
    reg [3:0] settle_cnt;
    reg [DW:0] code_q;
    reg [ACC_W-1:0] acc;
    reg pulse_hi;
    // Combinational results of the span mapping and the rate step
    reg [ACC_W-1:0] next_acc;
    reg [DW:0] sel_diff;
    reg [DW+1:0] wide_diff;
    reg [DW:0] code_now;
    reg [ACC_W-1:0] inc;
    // Bus decode
    wire rf_we;
    wire [31:0] rf_rdata;
    wire setup = psel && !penable;
    wire wr_take = setup && pwrite;
    wire awake = sleep_n && ctrl[`SVFC_CTRL_SLEEP_N];

    // Decodes a byte offset to a register index; unmapped offsets give 15,
    // which the bus logic answers with pslverr
    function [3:0] reg_index;
        input [11:0] a;
        begin
            case (a)
                `SVFC_OFS_CTRL: reg_index = 4'd0;
                `SVFC_OFS_IN_ONE: reg_index = 4'd1;
                `SVFC_OFS_IN_TWO: reg_index = 4'd2;
                `SVFC_OFS_IN_THREE: reg_index = 4'd3;
                `SVFC_OFS_IN_COMMON: reg_index = 4'd4;
                `SVFC_OFS_STATUS: reg_index = 4'd5;
                `SVFC_OFS_RATE: reg_index = 4'd6;
                default: reg_index = 4'hF;
            endcase
        end
    endfunction

    // Shadow store: last written word of every writable register
    assign rf_we = wr_take && (reg_index(paddr) < 4'd5);

    svfc_regfile #(.AW(3)) svfc_regfile_i (
        .pclk(pclk),
        .presetn(presetn),
        .we(rf_we),
        .waddr(paddr[4:2]),
        .wdata(pwdata),
        .raddr(paddr[4:2]),
        .rdata(rf_rdata)
    );

    // Channel routing and span mapping to a 0..2^DW-1 offset code
    always @* begin
        sel_diff = {(DW+1){1'b0}};
        wide_diff = {(DW+2){1'b0}};
        code_now = {(DW+1){1'b0}};
        if (ctrl[`SVFC_CTRL_SINGLE]) begin
            code_now = {1'b0, in_one};
        end else begin
            // Only the difference is used, so a common shift cancels
            case ({ctrl[`SVFC_CTRL_CHAN_MSB], ctrl[`SVFC_CTRL_CHAN_LSB]})
                2'b00: sel_diff = {1'b0, in_one} - {1'b0, in_common};
                2'b01: sel_diff = {1'b0, in_two} - {1'b0, in_common};
                2'b10: sel_diff = {1'b0, in_three} - {1'b0, in_common};
                default: sel_diff = {1'b0, in_one} - {1'b0, in_two};
            endcase
            // Doubling one bit wider lets gain two saturate instead of wrapping
            if (ctrl[`SVFC_CTRL_GAIN]) begin
                wide_diff = {sel_diff, 1'b0};
            end else begin
                wide_diff = {sel_diff[DW], sel_diff};
            end
            if (ctrl[`SVFC_CTRL_POL]) begin
                // Unipolar: 0..ref/gain; clip below zero and above full scale
                if (wide_diff[DW+1]) begin
                    code_now = {(DW+1){1'b0}};
                end else if (wide_diff[DW]) begin
                    code_now = {1'b0, {DW{1'b1}}};
                end else begin
                    code_now = {1'b0, wide_diff[DW-1:0]};
                end
            end else begin
                // Bipolar: halve, clip to half a span each way, offset by mid-scale
                case (wide_diff[DW+1:DW])
                    2'b01: code_now = {1'b0, {DW{1'b1}}};
                    2'b10: code_now = {(DW+1){1'b0}};
                    default: code_now = {1'b0, !wide_diff[DW], wide_diff[DW-1:1]};
                endcase
            end
        end
    end

    // Accumulator step: 5% floor plus 40% scaled by the code.
    // Each cycle adds one floor step plus eight times the code, and a pulse
    // fires on each wrap of the modulus: a zero code wraps every 20 cycles,
    // a full code adds nine floor steps per cycle, 0.45 of the clock. The
    // step stays below half the modulus, so two pulses never touch.
    always @* begin
        inc = FLOOR_INC + ({{(ACC_W-DW-1){1'b0}}, code_q} << 3);
        next_acc = acc + inc;
    end

    // Register map, one 32-bit word each:
    //   0x00 control: [0] channel lsb, [1] channel msb, [2] gain two,
    //        [3] unipolar, [4] single-channel, [5] crystal, [6] awake
    //   0x04..0x10 input codes one, two, three and common, bits [DW-1:0]
    //   0x14 status: [0] valid, [1] settling, [2] oscillator ready, [3] asleep
    //   0x18 current span code, read only
    // Writes land on the setup edge and the answer comes two edges later,
    // so a master that holds its request until pready always reads fresh data.
    // Status and code writes are dropped quietly, as they are read only.
    // APB slave: one wait state, then ready; unmapped offsets give pslverr
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl <= `SVFC_CTRL_RESET;
            in_one <= {DW{1'b0}};
            in_two <= {DW{1'b0}};
            in_three <= {DW{1'b0}};
            in_common <= {DW{1'b0}};
        end else begin
            case (st)
                ST_IDLE: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (setup) begin
                        st <= ST_RD;
                        if (pwrite) begin
                            case (reg_index(paddr))
                                4'd0: ctrl <= pwdata[6:0];
                                4'd1: in_one <= pwdata[DW-1:0];
                                4'd2: in_two <= pwdata[DW-1:0];
                                4'd3: in_three <= pwdata[DW-1:0];
                                4'd4: in_common <= pwdata[DW-1:0];
                                default: ;
                            endcase
                        end
                    end
                end
                ST_RD: begin
                    st <= ST_ACK;
                    pready <= 1'b1;
                    pslverr <= (reg_index(paddr) == 4'hF);
                    case (reg_index(paddr))
                        4'd0: prdata <= {25'h000_0000, ctrl};
                        4'd1, 4'd2, 4'd3, 4'd4: prdata <= rf_rdata & {{(32-DW){1'b0}}, {DW{1'b1}}};
                        4'd5: prdata <= {28'h000_0000, !awake, osc_ready,
                                         (settle_cnt != 4'd0), out_valid};
                        4'd6: prdata <= {{(31-DW){1'b0}}, code_q};
                        default: prdata <= 32'h0000_0000;
                    endcase
                end
                ST_ACK: begin
                    st <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // Crystal start-up: count from crystal select before pulses run.
    // Limitation: the count assumes pclk at its rated rate; a bench may shorten
    // it through the parameter so that crystal mode fits a short run.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt <= 32'h0000_0000;
            osc_ready <= 1'b0;
        end else if (!ctrl[`SVFC_CTRL_XTAL]) begin
            osc_cnt <= 32'h0000_0000;
            osc_ready <= 1'b1;
        end else if (osc_cnt >= OSC_START_CYC - 1) begin
            osc_ready <= 1'b1;
        end else begin
            osc_cnt <= osc_cnt + 32'h0000_0001;
            osc_ready <= 1'b0;
        end
    end

    // Settling: a code change or wake-up restarts the invalid window.
    // The single-channel variant reloads the longer count; the window is
    // counted on the registered code, so a step seen by the bus is covered.
    // Sleep and a cold oscillator hold the count loaded, never half-spent.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q <= {(DW+1){1'b0}};
            settle_cnt <= 4'd`SVFC_SETTLE_MULTI;
            out_valid <= 1'b0;
        end else begin
            code_q <= code_now;
            if (!awake || !osc_ready || code_now != code_q) begin
                settle_cnt <= ctrl[`SVFC_CTRL_SINGLE] ? 4'd`SVFC_SETTLE_SINGLE
                                                      : 4'd`SVFC_SETTLE_MULTI;
                out_valid <= 1'b0;
            end else if (settle_cnt != 4'd0) begin
                settle_cnt <= settle_cnt - 4'd1;
                out_valid <= 1'b0;
            end else begin
                out_valid <= 1'b1;
            end
        end
    end

    // Rate generator: a carry past the modulus fires one pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= {ACC_W{1'b0}};
            pulse_hi <= 1'b0;
            pulse_out <= 1'b0;
        end else if (!awake || !osc_ready) begin
            // Sleep or oscillator not yet running: generator held idle
            acc <= {ACC_W{1'b0}};
            pulse_hi <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            if (next_acc >= MODULUS) begin
                acc <= next_acc - MODULUS;
                pulse_hi <= 1'b1;
            end else begin
                acc <= next_acc;
                pulse_hi <= 1'b0;
            end
            // The extra stage keeps the pin straight off a flop.
            // One pclk wide, launched on the clock edge only
            pulse_out <= pulse_hi;
        end
    end

    // Clock echo: a registered toggle standing in for the inverted clock.
    // Limitation: a flop cannot echo its own clock, so the echo runs at half
    // rate; a true inverted copy would need a gate in the clock path.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_echo_out <= 1'b0;
        end else begin
            clock_echo_out <= !clock_echo_out;
        end
    end
endmodule

// ### svfc_regfile.v
/*
 Small register store for the converter model: eight 32-bit words with
 a registered read port. Assumes one clock and an active-low async reset.
*/
module svfc_regfile #(
    parameter AW = 3
) (
    input wire pclk,
    input wire presetn,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [31:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [31:0] rdata
);
    reg [31:0] mem [0:(1<<AW)-1];
    integer i;

    // Words clear on reset so reads are defined from the start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem[i] <= 32'h0000_0000;
            end
            rdata <= 32'h0000_0000;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

// ### sync_vfc_pulse_control_bench.sv
/*
 Self-checking bench for the pulse converter: APB set-up, gated counts.
 Assumes the design and counter files are compiled before this one.
*/
module sync_vfc_pulse_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic sleep_n = 1'b1;
    logic gate = 1'b0;
    logic clear = 1'b0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire pulse_out;
    wire clock_echo_out;
    wire out_valid;
    wire [15:0] count;
    int fail_count = 0;
    int compares = 0;
    logic [31:0] rd;
    logic err;

    always #50 pclk = ~pclk;

    // Short oscillator start so crystal mode fits the run
    svfc_pulse_top #(.OSC_START_CYC(20)) svfc_pulse_top_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_n(sleep_n),
        .pulse_out(pulse_out), .clock_echo_out(clock_echo_out), .out_valid(out_valid));
    svfc_pulse_counter svfc_pulse_counter_i (.pclk(pclk), .presetn(presetn), .clear(clear),
        .gate(gate), .pulse_in(pulse_out), .count(count));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task ran_out;
        fail_count++;
        $display("unexpected at %0t: wait ran out", $time);
        stop_test();
    endtask

    // Request held until pready is sampled high; data taken at that edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            ran_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_valid(output int n);
        n = 0;
        while (out_valid !== 1'b1) begin
            @(posedge pclk);
            n++;
            if (n > 300)
                ran_out();
        end
    endtask

    // Pulses seen in a 1000-cycle gate
    task measure(output logic [31:0] c);
        @(posedge pclk);
        clear <= 1'b1;
        @(posedge pclk);
        clear <= 1'b0;
        gate <= 1'b1;
        repeat (1000) @(posedge pclk);
        gate <= 1'b0;
        @(posedge pclk);
        c = {16'h0000, count};
    endtask

    // Accumulator phase leaves a count or two of slack
    function automatic logic [31:0] near(logic [31:0] c, logic [31:0] e);
        return (c + 2 >= e && c <= e + 2) ? e : c;
    endfunction

    task run_case(input logic [31:0] ctl, one, two, three, com, code);
        int n;
        logic [31:0] c;
        apb(1'b1, 12'h004, one);
        apb(1'b1, 12'h008, two);
        apb(1'b1, 12'h00C, three);
        apb(1'b1, 12'h010, com);
        apb(1'b1, 12'h000, ctl);
        wait_valid(n);
        measure(c);
        check(near(c, 50 + (400 * code) / 65535), 50 + (400 * code) / 65535);
    endtask

    task test_regs;
        logic e;
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0040);
        e = clock_echo_out;
        @(posedge pclk);
        check({31'h0, clock_echo_out}, {31'h0, !e});
        apb(1'b1, 12'h000, 32'h0000_0048);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0048);
        apb(1'b0, 12'h01C, 32'h0000_0000);
        check({err, rd[30:0]}, 32'h8000_0000);
        $display("test regs done");
    endtask

    task test_channels;
        run_case(32'h48, 32'hFFFF, 32'h0000, 32'h0000, 32'h0000, 32'hFFFF);
        run_case(32'h49, 32'hFFFF, 32'h4000, 32'h0000, 32'h0000, 32'h4000);
        run_case(32'h4A, 32'hFFFF, 32'h0000, 32'h8000, 32'h0000, 32'h8000);
        run_case(32'h4B, 32'h2000, 32'h0000, 32'hFFFF, 32'h0000, 32'h2000);
        $display("test channels done");
    endtask

    task test_spans;
        run_case(32'h40, 32'h7000, 32'h0000, 32'h0000, 32'h7000, 32'h8000);
        run_case(32'h40, 32'h0000, 32'h0000, 32'h0000, 32'hFFFF, 32'h0000);
        run_case(32'h4C, 32'h4000, 32'h0000, 32'h0000, 32'h0000, 32'h8000);
        run_case(32'h4C, 32'hC000, 32'h0000, 32'h0000, 32'h0000, 32'hFFFF);
        run_case(32'h44, 32'hC000, 32'h0000, 32'h0000, 32'h0000, 32'hFFFF);
        run_case(32'h48, 32'h0000, 32'h0000, 32'h0000, 32'h1000, 32'h0000);
        run_case(32'h54, 32'h8000, 32'h0000, 32'h0000, 32'h0000, 32'h8000);
        $display("test spans done");
    endtask

    task test_sleep;
        int n;
        logic [31:0] c;
        @(posedge pclk);
        sleep_n <= 1'b0;
        repeat (3) @(posedge pclk);
        check({31'h0, out_valid}, 32'h0);
        measure(c);
        check(c, 32'h0);
        sleep_n <= 1'b1;
        wait_valid(n);
        check(n >= 2, 32'h1);
        apb(1'b1, 12'h000, 32'h0000_0008);
        measure(c);
        check(c, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_0068);
        wait_valid(n);
        check(n >= 18, 32'h1);
        $display("test sleep done");
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_channels();
        test_spans();
        test_sleep();
        stop_test();
    end
endmodule

bind svfc_pulse_top svfc_pulse_checker svfc_pulse_checker_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .sleep_n(sleep_n),
    .pulse_out(pulse_out), .clock_echo_out(clock_echo_out), .out_valid(out_valid));
